// ### core_exec_map.vh
// Opcode fields, flag positions and reset values of the execute core
`ifndef CORE_EXEC_MAP_VH
`define CORE_EXEC_MAP_VH
`define OPC_ADD_LIT 6'h1C
`define OPC_AND_LIT 6'h1B
`define OPC_OR_LIT 6'h1A
`define OPC_XOR_LIT 6'h1F
`define OPC_LOAD_LIT 6'h19
`define OPC_RETURN_LIT 6'h18
`define OPC_ADD_REG 6'h07
`define OPC_AND_REG 6'h05
`define OPC_COMP 6'h09
`define OPC_DEC 6'h03
`define OPC_CLR 6'h01
`define OPC_BIT_GRP 3'h2
`define BIT_CLR 2'h0
`define BIT_SET 2'h1
`define BIT_SKZ 2'h2
`define BIT_SKO 2'h3
`define CALL_GRP 2'h2
`define INS_IDLE 14'h0000
`define INS_SLEEP 14'h0003
`define INS_WDCLR 14'h0004
`define INS_ACC_CLR 14'h0140
`define INS_SUB_RETURN 14'h0040
`define INS_INT_RETURN 14'h0060
`define INS_LK_LOW 14'h0050
`define INS_LK_HIGH 14'h0058
`define ZERO_POS 2
`define HALF_POS 1
`define CARRY_POS 0
`define ACC_RST 8'h00
`define STAT_RST 3'h0
`define PC_RST 12'h000
`define CNT_RST 8'h00
`endif

// ### core_exec.v
// Decode and execute core for 14-bit instruction words
`timescale 1ns/1ps
`include "core_exec_map.vh"

// Behaviour
// - literal add to accumulator, flags C HC Z
// - register add, destination bit selects target
// - literal AND, zero flag only
// - register AND, destination select, zero only
// - bit clear in register 00h-3Fh
// - bit set in register 00h-3Fh
// - skip next when tested bit zero
// - skip next when tested bit one
// - call pushes PC+1, loads 12-bit target
// - register clear writes zero, sets zero
// - accumulator clear, sets zero flag
// - watchdog clear resets both counters, flags
// - complement register, destination select, zero
// - decrement register, destination select, zero
// - subroutine return pops PC, two cycles
// - interrupt return pops PC, ends service
// - return with literal into accumulator
// - sleep enters power-down, updates flags
// - literal XOR and OR, zero only
// - literal load no flags; idle one cycle
// - ROM lookup high or low, two cycles
module core_exec (
    // Clock and reset
    input wire CLK_SYS,
    input wire RST,
    // Program memory
    input wire [13:0] INSTR,
    output reg [11:0] PC_OUT,
    output reg [11:0] LOOKUP_ADDR,
    output reg LOOKUP_REQ,
    input wire [13:0] LOOKUP_DATA,
    // File register port
    output reg [6:0] FR_ADDR,
    input wire [7:0] FR_RDATA,
    output reg [7:0] FR_WDATA,
    output reg FR_WE,
    // Core state
    output reg [7:0] ACC,
    output reg ZERO_FLAG,
    output reg HALF_CARRY_FLAG,
    output reg CARRY_FLAG,
    output reg TIMEOUT_FLAG,
    output reg POWERDOWN_FLAG,
    output reg POWER_DOWN,
    output reg INT_SERVICE,
    output reg [7:0] WATCHDOG_COUNTER,
    output reg [7:0] WAKEUP_COUNTER,
    input wire [11:0] LOOKUP_BASE
);
    localparam ST_EXEC = 2'h0;
    localparam ST_BUBBLE = 2'h1;
    localparam ST_LOOKUP = 2'h2;
    localparam ST_SLEEP = 2'h3;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [11:0] stack_ff [0:7];
    reg [2:0] sp_ff;
    reg [2:0] nxt_sp;
    reg push;
    reg lk_high_ff;
    reg nxt_lk_high;
    reg hold_ff;
    reg nxt_hold;
    reg [11:0] nxt_pc;
    reg [7:0] nxt_acc;
    reg [2:0] nxt_stat;
    reg nxt_to;
    reg nxt_powerdown;
    reg nxt_pdn;
    reg nxt_isr;
    reg nxt_we;
    reg [7:0] nxt_wdata;
    reg [7:0] nxt_wd;
    reg [7:0] nxt_wk;
    reg nxt_lreq;
    reg [7:0] res;
    reg [8:0] sum;
    reg [4:0] hsum;
    reg bitval;
    reg [7:0] mask;
    reg to_w;
    reg [5:0] op6;
    wire [7:0] lit = INSTR[7:0];
    wire [2:0] bsel = INSTR[8:6];
    wire dbit = INSTR[7];
    wire [11:0] pc_inc = PC_OUT + 12'h001;
    wire [11:0] stack_top = stack_ff[sp_ff - 3'h1];
    integer i;

    // File address decoded straight from the current word
    always @* begin
        if (INSTR[13:11] == `OPC_BIT_GRP)
            FR_ADDR = {1'b0, INSTR[5:0]};
        else
            FR_ADDR = INSTR[6:0];
    end

    always @* begin
        nxt_state = ST_EXEC;
        nxt_pc = pc_inc;
        nxt_acc = ACC;
        nxt_stat = {ZERO_FLAG, HALF_CARRY_FLAG, CARRY_FLAG};
        nxt_to = TIMEOUT_FLAG;
        nxt_powerdown = POWERDOWN_FLAG;
        nxt_pdn = POWER_DOWN;
        nxt_isr = INT_SERVICE;
        nxt_we = 1'b0;
        nxt_wdata = FR_WDATA;
        nxt_wd = WATCHDOG_COUNTER + 8'h01;
        nxt_wk = WAKEUP_COUNTER + 8'h01;
        nxt_sp = sp_ff;
        push = 1'b0;
        nxt_lreq = 1'b0;
        nxt_lk_high = lk_high_ff;
        nxt_hold = 1'b0;
        res = 8'h00;
        sum = 9'h000;
        hsum = 5'h00;
        to_w = 1'b1;
        op6 = INSTR[13:8];
        mask = 8'h01 << bsel;
        bitval = |(FR_RDATA & mask);
        case (state_ff)
            ST_BUBBLE: begin
                // Fetched word discarded; jumps keep their target
                if (hold_ff)
                    nxt_pc = PC_OUT;
                else
                    nxt_pc = pc_inc;
            end
            ST_LOOKUP: begin
                nxt_pc = PC_OUT;
                if (lk_high_ff)
                    nxt_acc = {2'b00, LOOKUP_DATA[13:8]};
                else
                    nxt_acc = LOOKUP_DATA[7:0];
            end
            ST_SLEEP: begin
                nxt_pc = PC_OUT;
                nxt_state = ST_SLEEP;
            end
            default: begin
                if (INSTR[13:12] == `CALL_GRP) begin
                    push = 1'b1;
                    nxt_sp = sp_ff + 3'h1;
                    nxt_pc = INSTR[11:0];
                    nxt_hold = 1'b1;
                    nxt_state = ST_BUBBLE;
                end else if (INSTR[13:11] == `OPC_BIT_GRP &&
                        !INSTR[10]) begin
                    nxt_we = 1'b1;
                    if (INSTR[10:9] == `BIT_CLR)
                        nxt_wdata = FR_RDATA & ~mask;
                    else
                        nxt_wdata = FR_RDATA | mask;
                end else if (INSTR[13:11] == `OPC_BIT_GRP) begin
                    if (INSTR[10:9] == `BIT_SKZ && !bitval)
                        nxt_state = ST_BUBBLE;
                    if (INSTR[10:9] == `BIT_SKO && bitval)
                        nxt_state = ST_BUBBLE;
                end else begin
                    case (op6)
                        `OPC_ADD_LIT, `OPC_ADD_REG: begin
                            res = (op6 == `OPC_ADD_LIT) ? lit : FR_RDATA;
                            sum = {1'b0, ACC} + {1'b0, res};
                            hsum = {1'b0, ACC[3:0]} + {1'b0, res[3:0]};
                            res = sum[7:0];
                            to_w = (op6 == `OPC_ADD_LIT) | ~dbit;
                            nxt_stat = {res == 8'h00, hsum[4], sum[8]};
                        end
                        `OPC_AND_LIT, `OPC_OR_LIT, `OPC_XOR_LIT: begin
                            if (op6 == `OPC_AND_LIT)
                                res = ACC & lit;
                            else if (op6 == `OPC_OR_LIT)
                                res = ACC | lit;
                            else
                                res = ACC ^ lit;
                            nxt_stat[`ZERO_POS] = (res == 8'h00);
                        end
                        `OPC_AND_REG, `OPC_COMP, `OPC_DEC: begin
                            if (op6 == `OPC_AND_REG)
                                res = ACC & FR_RDATA;
                            else if (op6 == `OPC_COMP)
                                res = ~FR_RDATA;
                            else
                                res = FR_RDATA - 8'h01;
                            to_w = ~dbit;
                            nxt_stat[`ZERO_POS] = (res == 8'h00);
                        end
                        `OPC_LOAD_LIT:
                            res = lit;
                        `OPC_RETURN_LIT: begin
                            res = lit;
                            nxt_sp = sp_ff - 3'h1;
                            nxt_pc = stack_top;
                            nxt_hold = 1'b1;
                            nxt_state = ST_BUBBLE;
                        end
                        `OPC_CLR: begin
                            if (dbit) begin
                                to_w = 1'b0;
                                nxt_stat[`ZERO_POS] = 1'b1;
                            end else if (INSTR == `INS_ACC_CLR) begin
                                nxt_stat[`ZERO_POS] = 1'b1;
                            end else begin
                                res = ACC;
                            end
                        end
                        default: begin
                            res = ACC;
                            case (INSTR)
                                `INS_SUB_RETURN: begin
                                    nxt_sp = sp_ff - 3'h1;
                                    nxt_pc = stack_top;
                                    nxt_hold = 1'b1;
                                    nxt_state = ST_BUBBLE;
                                end
                                `INS_INT_RETURN: begin
                                    nxt_sp = sp_ff - 3'h1;
                                    nxt_pc = stack_top;
                                    nxt_isr = 1'b0;
                                    nxt_hold = 1'b1;
                                    nxt_state = ST_BUBBLE;
                                end
                                `INS_WDCLR: begin
                                    nxt_wd = `CNT_RST;
                                    nxt_wk = `CNT_RST;
                                    nxt_to = 1'b1;
                                    nxt_powerdown = 1'b1;
                                end
                                `INS_SLEEP: begin
                                    nxt_wd = `CNT_RST;
                                    nxt_to = 1'b1;
                                    nxt_powerdown = 1'b0;
                                    nxt_pdn = 1'b1;
                                    nxt_state = ST_SLEEP;
                                end
                                `INS_LK_LOW, `INS_LK_HIGH: begin
                                    nxt_lreq = 1'b1;
                                    nxt_lk_high = INSTR[3];
                                    nxt_state = ST_LOOKUP;
                                end
                                default:
                                    res = ACC;
                            endcase
                        end
                    endcase
                    if (to_w)
                        nxt_acc = res;
                    else begin
                        nxt_we = 1'b1;
                        nxt_wdata = res;
                    end
                end
            end
        endcase
    end

    // Sequencer: state, program counter, stack pointer
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_ff <= ST_EXEC;
            PC_OUT <= `PC_RST;
            sp_ff <= 3'h0;
            hold_ff <= 1'b0;
            lk_high_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            PC_OUT <= nxt_pc;
            sp_ff <= nxt_sp;
            hold_ff <= nxt_hold;
            lk_high_ff <= nxt_lk_high;
        end
    end

    // Working register and arithmetic flags
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ACC <= `ACC_RST;
            {ZERO_FLAG, HALF_CARRY_FLAG, CARRY_FLAG} <= `STAT_RST;
        end else begin
            ACC <= nxt_acc;
            {ZERO_FLAG, HALF_CARRY_FLAG, CARRY_FLAG} <= nxt_stat;
        end
    end

    // Power and service flags; power-down ends only with reset
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TIMEOUT_FLAG <= 1'b1;
            POWERDOWN_FLAG <= 1'b1;
            POWER_DOWN <= 1'b0;
            INT_SERVICE <= 1'b0;
        end else begin
            TIMEOUT_FLAG <= nxt_to;
            POWERDOWN_FLAG <= nxt_powerdown;
            POWER_DOWN <= nxt_pdn;
            INT_SERVICE <= nxt_isr;
        end
    end

    // File write launched one cycle after decode
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            FR_WE <= 1'b0;
            FR_WDATA <= 8'h00;
        end else begin
            FR_WE <= nxt_we;
            FR_WDATA <= nxt_wdata;
        end
    end

    // Free-running timer counters
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            WATCHDOG_COUNTER <= `CNT_RST;
            WAKEUP_COUNTER <= `CNT_RST;
        end else begin
            WATCHDOG_COUNTER <= nxt_wd;
            WAKEUP_COUNTER <= nxt_wk;
        end
    end

    // Lookup address follows the working register every cycle
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            LOOKUP_REQ <= 1'b0;
            LOOKUP_ADDR <= `PC_RST;
        end else begin
            LOOKUP_REQ <= nxt_lreq;
            LOOKUP_ADDR <= {LOOKUP_BASE[11:8], ACC};
        end
    end

    // Return stack, eight entries, pointer wraps
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            for (i = 0; i < 8; i = i + 1)
                stack_ff[i] <= `PC_RST;
        end else if (push) begin
            stack_ff[sp_ff] <= pc_inc;
        end
    end
endmodule // core_exec

// ### core_exec_assertions.sv
// Port assertions for the execute core
`timescale 1ns/1ps
module core_exec_checker (
    // Clock and reset
    input wire CLK_SYS,
    input wire RST,
    // Observed ports
    input wire [13:0] INSTR,
    input wire [11:0] PC_OUT,
    input wire [7:0] FR_RDATA,
    input wire [7:0] FR_WDATA,
    input wire FR_WE,
    input wire [7:0] ACC,
    input wire ZERO_FLAG,
    input wire CARRY_FLAG,
    input wire TIMEOUT_FLAG,
    input wire POWERDOWN_FLAG,
    input wire POWER_DOWN,
    input wire [7:0] WATCHDOG_COUNTER,
    // Lookup port
    input wire LOOKUP_REQ,
    input wire [13:0] LOOKUP_DATA
);
    reg bub_ff;
    wire [5:0] op = INSTR[13:8];
    wire [7:0] k = INSTR[7:0];
    wire [11:0] tgt = INSTR[11:0];
    wire skip = INSTR[13:11] == 3'h2 && INSTR[10]
        && FR_RDATA[INSTR[8:6]] == INSTR[9];
    wire two = INSTR[13:12] == 2'h2 || op == 6'h18 || skip
        || INSTR == 14'h0040 || INSTR == 14'h0060
        || INSTR == 14'h0050 || INSTR == 14'h0058;
    wire ex = !bub_ff && !POWER_DOWN;
    wire nxt_bub = ex && two;
    wire [7:0] lk_hi = {2'b00, LOOKUP_DATA[13:8]};
    wire [7:0] lk_lo = LOOKUP_DATA[7:0];
    // Tracks the discarded word after two-cycle instructions
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            bub_ff <= 1'b0;
        end else begin
            bub_ff <= nxt_bub;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_call; ex && INSTR[13:12] == 2'h2; endsequence
    sequence s_land; PC_OUT == $past(tgt) ##1 $stable(PC_OUT); endsequence
    sequence s_hold; ##1 $stable(ACC); endsequence
    sequence s_lkup; LOOKUP_REQ ##1 !LOOKUP_REQ && ACC ==
        ($past(INSTR, 2) == 14'h0058 ? $past(lk_hi) : $past(lk_lo));
    endsequence
    sequence s_back; $stable(ZERO_FLAG) && $stable(CARRY_FLAG)
        ##1 $stable(PC_OUT); endsequence
    property p_lkup; ex && (INSTR == 14'h0050 || INSTR == 14'h0058) |=>
        s_lkup;
    endproperty
    a_lkup: assert property (p_lkup)
        else $error("lookup request or data wrong");
    property p_ret; ex && (INSTR == 14'h0040 || INSTR == 14'h0060) |=>
        s_back;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return changed flags or left target");
    property p_add; ex && op == 6'h1C |=> ACC == $past(ACC) + $past(k);
    endproperty
    a_add: assert property (p_add)
        else $error("literal add result wrong");
    property p_and; ex && op == 6'h1B |=>
        ACC == ($past(ACC) & $past(k)) && $stable(CARRY_FLAG);
    endproperty
    a_and: assert property (p_and)
        else $error("literal and result wrong");
    property p_load; ex && op == 6'h19 |=>
        ACC == $past(k) && $stable(ZERO_FLAG);
    endproperty
    a_load: assert property (p_load)
        else $error("literal load wrong");
    property p_fclr; ex && INSTR[13:7] == 7'h03 |=>
        FR_WE && FR_WDATA == 8'h00 && ZERO_FLAG;
    endproperty
    a_fclr: assert property (p_fclr)
        else $error("register clear wrong");
    property p_call; s_call |=> s_land; endproperty
    a_call: assert property (p_call)
        else $error("call target wrong");
    property p_skip; ex && skip |=> s_hold; endproperty
    a_skip: assert property (p_skip)
        else $error("skipped word was executed");
    property p_wdog; ex && INSTR == 14'h0004 |=>
        WATCHDOG_COUNTER == 8'h00 && TIMEOUT_FLAG && POWERDOWN_FLAG;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog clear wrong");
    property p_sleep; ex && INSTR == 14'h0003 |=>
        POWER_DOWN && TIMEOUT_FLAG && !POWERDOWN_FLAG ##1 $stable(ACC);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep entry wrong");
endmodule // core_exec_checker
bind core_exec core_exec_checker chk_u (.CLK_SYS(CLK_SYS), .RST(RST),
    .INSTR(INSTR), .PC_OUT(PC_OUT), .FR_RDATA(FR_RDATA),
    .FR_WDATA(FR_WDATA), .FR_WE(FR_WE), .ACC(ACC), .ZERO_FLAG(ZERO_FLAG),
    .CARRY_FLAG(CARRY_FLAG), .TIMEOUT_FLAG(TIMEOUT_FLAG),
    .POWERDOWN_FLAG(POWERDOWN_FLAG), .POWER_DOWN(POWER_DOWN),
    .WATCHDOG_COUNTER(WATCHDOG_COUNTER), .LOOKUP_REQ(LOOKUP_REQ),
    .LOOKUP_DATA(LOOKUP_DATA));

// ### tb.sv
// Random and directed bench for the execute core
`timescale 1ns/1ps
`include "core_exec_map.vh"
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [13:0] ins = 14'h0000;
    reg [11:0] base = 12'h000;
    wire [11:0] pc, la;
    wire [6:0] fa;
    wire [7:0] fw, acc, wdc, wkc;
    wire lr, we, zf, hf, cf, tof, pdf, pdn, isv;
    wire [13:0] ld = {la[11:6], ~la[7:0]};
    reg [7:0] fm [0:127];
    reg [6:0] wa_ff = 7'h00;
    integer bad_count = 0;
    integer checks_done = 0;
    integer i, j;
    reg [31:0] rn = 32'hE404;
    reg [7:0] ea, er, k;
    reg [9:0] r;
    reg [11:0] pr;
    reg ez = 1'b0, ec = 1'b0, eh = 1'b0;
    localparam [53:0] OPS = {`OPC_DEC, `OPC_COMP, `OPC_AND_REG,
        `OPC_ADD_REG, `OPC_LOAD_LIT, `OPC_XOR_LIT, `OPC_OR_LIT,
        `OPC_AND_LIT, `OPC_ADD_LIT};
    core_exec dut_u (.CLK_SYS(clk), .RST(rst), .INSTR(ins), .PC_OUT(pc),
        .LOOKUP_ADDR(la), .LOOKUP_REQ(lr), .LOOKUP_DATA(ld),
        .FR_ADDR(fa), .FR_RDATA(fm[fa]), .FR_WDATA(fw), .FR_WE(we),
        .ACC(acc), .ZERO_FLAG(zf), .HALF_CARRY_FLAG(hf), .CARRY_FLAG(cf),
        .TIMEOUT_FLAG(tof), .POWERDOWN_FLAG(pdf), .POWER_DOWN(pdn),
        .INT_SERVICE(isv), .WATCHDOG_COUNTER(wdc),
        .WAKEUP_COUNTER(wkc), .LOOKUP_BASE(base));
    initial forever #25 clk = ~clk;
    // Write lands one cycle after decode
    always @(posedge clk) begin
        if (we) fm[wa_ff] <= fw;
        wa_ff <= fa;
    end
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Returns half carry, carry and result
    function [9:0] alu(input integer o, input [7:0] a, input [7:0] v);
        case (o)
            0, 5: alu = {({1'b0, a[3:0]} + v[3:0]) > 5'h0F, {1'b0, a} + v};
            1, 6: alu = {2'b00, a & v};
            2: alu = {2'b00, a | v};
            3: alu = {2'b00, a ^ v};
            7: alu = {2'b00, ~v};
            8: alu = {2'b00, v - 8'h01};
            default: alu = {2'b00, v};
        endcase
    endfunction
    task chk(input string nm, input [23:0] e, input [23:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task run(input [13:0] w0, input [13:0] w1);
        begin
            ins = w0;
            @(negedge clk) ins = w1;
            @(negedge clk) ins = 14'h0000;
            @(negedge clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        #200000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    initial begin
        for (i = 0; i < 128; i = i + 1) begin
            rn = lfsr(rn);
            fm[i] = rn[7:0];
        end
        repeat (6) @(negedge clk);
        rst = 1'b0;
        ea = 8'h00;
        for (i = 0; i < 300; i = i + 1) begin
            rn = lfsr(rn);
            j = rn[31:28] % 9;
            k = rn[7:0];
            base = rn[27:16];
            if (i < 2) begin
                j = 4 - 4 * i;
                k = i ? 8'h08 : 8'hF8;
            end
            er = fm[rn[14:8]];
            r = alu(j, ea, j < 5 ? k : er);
            run({OPS[6*j +: 6], j < 5 ? k : rn[15:8]}, 14'h0000);
            if (j < 5 || !rn[15]) ea = r[7:0];
            if (j != 4) ez = r[7:0] == 8'h00;
            if (j == 0 || j == 5) {eh, ec} = r[9:8];
            chk("acc", ea, acc);
            chk("flags", {ez, eh, ec}, {zf, hf, cf});
            if (j > 4 && rn[15]) chk("file", r[7:0], fm[rn[14:8]]);
        end
        $display("random ops done");
        run(14'h0140, 14'h0000);
        chk("acc clear", 9'h100, {zf, acc});
        ea = 8'h00;
        ez = 1'b1;
        run({7'h03, rn[6:0]}, 14'h0000);
        chk("file clear", 9'h100, {zf, fm[rn[6:0]]});
        pr = pc + 12'h003;
        run(14'h0070, 14'h0000);
        chk("undefined", {ez, pr, ea}, {zf, pc, acc});
        $display("clear ops done");
        for (i = 0; i < 24; i = i + 1) begin
            rn = lfsr(rn);
            er = fm[rn[5:0]];
            k = rn[23:16];
            if (!(rn[10] && er[rn[8:6]] == rn[9])) ea = k;
            if (!rn[10]) er[rn[8:6]] = rn[9];
            run({3'h2, rn[10:0]}, {`OPC_LOAD_LIT, k});
            chk("bit", {ez, er, ea}, {zf, fm[rn[5:0]], acc});
        end
        $display("bit ops done");
        for (i = 0; i < 3; i = i + 1) begin
            rn = lfsr(rn);
            pr = pc + 12'h002;
            run({2'h2, rn[11:0]}, rn[27:14]);
            chk("call", (rn[11:0] + 12'h001) & 12'hFFF, pc);
            run(i == 0 ? 14'h0040 : i == 1 ? 14'h0060 : {6'h18, rn[7:0]},
                rn[29:16]);
            if (i == 2) ea = rn[7:0];
            chk("return", {1'b0, ez, pr, ea}, {isv, zf, pc, acc});
        end
        $display("call and return done");
        for (i = 0; i < 2; i = i + 1) begin
            run(i ? 14'h0058 : 14'h0050, 14'h0000);
            ea = i ? {2'b00, base[11:8], ea[7:6]} : ~ea;
            chk("lookup", ea, acc);
        end
        run(14'h0004, 14'h0000);
        chk("wdog", 3'h7, {tof, pdf, wdc < 8'h04 && wkc < 8'h04});
        pr = pc + 12'h001;
        run(14'h0003, {`OPC_ADD_LIT, 8'h11});
        chk("sleep", {3'h6, pr, ea}, {pdn, tof, pdf, pc, acc});
        rst = 1'b1;
        @(negedge clk);
        chk("reset", {3'h3, 20'h00000}, {pdn, tof, pdf, pc, acc});
        rst = 1'b0;
        run({`OPC_ADD_LIT, 8'h11}, 14'h0000);
        chk("restart", 8'h11, acc);
        $display("control ops done");
        tally_and_finish;
    end
endmodule // tb
